// ===== core/sas_stop_ctrl.sv
// Servo stop-method, outage ride-through and overspeed controller
// Operation
// - Group-one alarm stops the motor like servo off, per selector.
// - Selector 0: brake stop, then hold in brake mode.
// - Selector 1: brake stop, then coast with power removed.
// - Selector 2: coast to rest, stay coasting with power removed.
// - Group-two field 0: zero-speed stop, then state per selector.
// - Group-two field 1: group-two alarm stops like group-one.
// - Group-two field ignored under force control.
// - Supply off always forces a brake stop.
// - Main off detected as outage; hold 20 to 1000 ms, immediate.
// - Supply back before hold time: servo keeps running.
// - Outage reaching hold time switches servo off.
// - Control supply loss ignores hold time, normal power off.
// - Undervoltage during outage ignores hold time, brakes as power off.
// - Top speed 1 to 100 x 100 mm/s, default 50, at restart.
// - Zero-speed stop forces internal speed reference to zero.
module sas_stop_ctrl
	import sas_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Supply and alarm pins
	input wire logic main_supply_ok,
	input wire logic control_supply_ok,
	input wire logic undervoltage_alarm,
	input wire logic group_one_alarm,
	input wire logic group_two_alarm,
	// Host control pins
	input wire logic servo_on_request,
	input wire logic force_mode,
	input wire logic motor_at_rest,
	// Same-clock motion data
	input wire logic [15:0] speed_ref_in,
	input wire logic [15:0] measured_speed,
	// Power stage
	output logic power_enable,
	output logic short_circuit_brake,
	output logic servo_running,
	output logic [15:0] speed_ref_out,
	// Interrupt
	output logic irq
);
	sas_state_e state, next_state;
	logic [PIN_W-1:0] pins;
	logic [1:0] sel_pend, servo_off_stop_selector;
	logic g2_pend, group_two_stop_field;
	logic [6:0] speed_pend, top_speed_setting;
	logic [9:0] outage_hold_time;
	logic [IRQ_W-1:0] irq_stat, irq_mask;
	logic [7:0] dp_addr;
	logic dp_write;
	logic overspeed, alarm_latched, armed;
	logic outage_active, outage_expired;
	logic prev_outage, prev_ctrl_ok;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sas_sync u_sync (
		.clk(clk),
		.reset(reset),
		.pin_in({motor_at_rest, force_mode, servo_on_request,
			group_two_alarm, group_one_alarm, undervoltage_alarm,
			control_supply_ok, main_supply_ok}),
		.pin_sync(pins)
	);

	wire main_ok = pins[0];
	wire ctrl_ok = pins[1];
	wire uv_s = pins[2];
	wire g1_s = pins[3];
	wire g2_s = pins[4];
	wire servo_on_s = pins[5];
	wire force_s = pins[6];
	wire rest_s = pins[7];

	sas_outage_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
		.clk(clk),
		.reset(reset),
		.main_lost(!main_ok),
		.hold_ms(outage_hold_time),
		.outage_active(outage_active),
		.outage_expired(outage_expired)
	);

	// Bus decode
	wire addr_phase = hsel && hready && htrans[1];
	wire wr_en = dp_write;
	wire wr_config = wr_en && dp_addr == OFF_CONFIG;
	wire wr_hold = wr_en && dp_addr == OFF_HOLD;
	wire wr_speed = wr_en && dp_addr == OFF_SPEED;
	wire wr_irq_stat = wr_en && dp_addr == OFF_IRQ_STAT;
	wire wr_irq_mask = wr_en && dp_addr == OFF_IRQ_MASK;
	wire wr_cmd = wr_en && dp_addr == OFF_COMMAND;
	wire do_restart = wr_cmd && hwdata[CMD_RESTART_BIT];
	wire do_clear = wr_cmd && hwdata[CMD_CLEAR_BIT];
	wire [9:0] hold_wr = hwdata[9:0];
	wire [6:0] speed_wr = hwdata[6:0];
	wire hold_ok = hwdata[31:10] == 22'h0 && hold_wr >= HOLD_MIN
		&& hold_wr <= HOLD_MAX;
	wire speed_ok = hwdata[31:7] == 25'h0 && speed_wr >= SPEED_MIN
		&& speed_wr <= SPEED_MAX;

	wire [15:0] speed_limit = 16'(top_speed_setting) * 16'(SPEED_UNIT_MMS);
	wire over_limit = measured_speed > speed_limit;

	// Stop cause decode
	// Supply loss forces brake
	wire power_fault = !ctrl_ok || outage_expired || (uv_s && outage_active);
	wire g2_zero = g2_s && !force_s && group_two_stop_field == 1'b0;
	wire g2_as_g1 = g2_s && !g2_zero;
	wire alarm_sel = g1_s || overspeed || g2_as_g1
		|| (uv_s && !outage_active);
	wire [2:0] sel_stop_code = (servo_off_stop_selector == SEL_COAST)
		? ST_COAST_STOP : ST_BRAKE_STOP;
	wire [2:0] end_code = (servo_off_stop_selector == SEL_BRAKE_HOLD)
		? ST_OFF_BRAKE : ST_OFF_COAST;
	wire sel_stop_req = alarm_sel || !servo_on_s;
	wire start_ok = servo_on_s && armed && !alarm_latched && main_ok
		&& ctrl_ok && !uv_s;

	// Interrupt events
	wire [IRQ_W-1:0] irq_set;
	assign irq_set[IRQ_G1] = g1_s && !alarm_latched;
	assign irq_set[IRQ_G2] = g2_s && !alarm_latched;
	assign irq_set[IRQ_OVERSPEED] = over_limit && !overspeed;
	assign irq_set[IRQ_OUTAGE] = outage_active && !prev_outage;
	assign irq_set[IRQ_EXPIRE] = outage_expired && state == ST_RUN;
	assign irq_set[IRQ_CTRL_LOSS] = !ctrl_ok && prev_ctrl_ok;
	assign irq_set[IRQ_UNDERVOLT] = uv_s && !alarm_latched;
	wire [IRQ_W-1:0] irq_clr = wr_irq_stat ? hwdata[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

	// Read mux
	wire [31:0] status_word = {16'h0000, 1'b0, top_speed_setting,
		overspeed, alarm_latched, outage_expired, outage_active,
		1'b0, 3'(state)};
	wire [31:0] read_mux =
		haddr == OFF_CONFIG ? {27'h0, g2_pend, 2'h0, sel_pend} :
		haddr == OFF_HOLD ? {22'h0, outage_hold_time} :
		haddr == OFF_SPEED ? {25'h0, speed_pend} :
		haddr == OFF_STATUS ? status_word :
		haddr == OFF_IRQ_STAT ? {25'h0, irq_stat} :
		haddr == OFF_IRQ_MASK ? {25'h0, irq_mask} : 32'h0;

	// State transitions
	always_comb
	begin
		next_state = state;
		case (state)
			ST_RUN:
			begin
				if (power_fault)
					next_state = ST_BRAKE_STOP;
				else if (sel_stop_req)
					next_state = sas_state_e'(sel_stop_code);
				else if (g2_zero)
					next_state = ST_ZERO_STOP;
			end
			ST_ZERO_STOP:
			begin
				if (power_fault)
					next_state = ST_BRAKE_STOP;
				else if (alarm_sel)
					next_state = sas_state_e'(sel_stop_code);
				else if (rest_s)
					next_state = sas_state_e'(end_code);
			end
			ST_COAST_STOP:
			begin
				if (power_fault)
					next_state = ST_BRAKE_STOP;
				else if (rest_s)
					next_state = sas_state_e'(end_code);
			end
			ST_BRAKE_STOP:
			begin
				if (rest_s)
					next_state = power_fault ? ST_OFF_BRAKE
						: sas_state_e'(end_code);
			end
			ST_OFF_COAST, ST_OFF_BRAKE:
			begin
				if (start_ok)
					next_state = ST_RUN;
			end
			default:
				next_state = ST_OFF_COAST;
		endcase
	end

	// Bus slave
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dp_addr <= '0;
			dp_write <= 1'b0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			dp_write <= addr_phase && hwrite;
			if (addr_phase)
				dp_addr <= haddr;
			if (addr_phase && !hwrite)
				hrdata <= read_mux;
		end
	end

	// Settings; pending copies load at restart
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sel_pend <= SEL_RESET;
			g2_pend <= G2_RESET;
			speed_pend <= SPEED_RESET;
			servo_off_stop_selector <= SEL_RESET;
			group_two_stop_field <= G2_RESET;
			top_speed_setting <= SPEED_RESET;
			outage_hold_time <= HOLD_RESET;
			irq_mask <= IRQ_MASK_RESET;
		end
		else
		begin
			if (wr_config && hwdata[1:0] <= SEL_COAST)
				sel_pend <= hwdata[CFG_SEL_LSB +: 2];
			if (wr_config)
				g2_pend <= hwdata[CFG_G2_BIT];
			if (wr_speed && speed_ok)
				speed_pend <= speed_wr;
			// Hold time takes effect at once
			if (wr_hold && hold_ok)
				outage_hold_time <= hold_wr;
			if (wr_irq_mask)
				irq_mask <= hwdata[IRQ_W-1:0];
			if (do_restart)
			begin
				servo_off_stop_selector <= sel_pend;
				group_two_stop_field <= g2_pend;
				top_speed_setting <= speed_pend;
			end
		end
	end

	// Drive state and latches
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= ST_OFF_COAST;
			overspeed <= 1'b0;
			alarm_latched <= 1'b0;
			armed <= 1'b0;
			irq_stat <= '0;
			prev_outage <= 1'b0;
			prev_ctrl_ok <= 1'b0;
		end
		else
		begin
			state <= next_state;
			prev_outage <= outage_active;
			prev_ctrl_ok <= ctrl_ok;
			irq_stat <= next_irq_stat;
			overspeed <= over_limit || (overspeed && !do_clear);
			alarm_latched <= g1_s || g2_s || uv_s || over_limit
				|| (alarm_latched && !do_clear);
			armed <= !servo_on_s || (armed && next_state != ST_RUN);
		end
	end

	// Power-stage outputs
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			power_enable <= 1'b0;
			short_circuit_brake <= 1'b0;
			servo_running <= 1'b0;
			speed_ref_out <= '0;
			irq <= 1'b0;
		end
		else
		begin
			power_enable <= next_state == ST_RUN
				|| next_state == ST_ZERO_STOP;
			short_circuit_brake <= next_state == ST_BRAKE_STOP
				|| next_state == ST_OFF_BRAKE;
			servo_running <= next_state == ST_RUN;
			speed_ref_out <= next_state == ST_RUN ? speed_ref_in : '0;
			irq <= |(next_irq_stat & irq_mask);
		end
	end

	sequence s_running_clean;
		state == ST_RUN && ctrl_ok && !outage_expired && !uv_s;
	endsequence

	a_g1_selector: assert property (
		s_running_clean and g1_s |=> state == sas_state_e'(sel_stop_code))
		else $error("group one alarm did not take selector stop");
	a_sel0_hold: assert property (
		state == ST_BRAKE_STOP && rest_s && !power_fault
		&& servo_off_stop_selector == SEL_BRAKE_HOLD
		|=> state == ST_OFF_BRAKE && short_circuit_brake)
		else $error("selector 0 did not hold brake");
	a_sel1_coast: assert property (
		state == ST_BRAKE_STOP && rest_s && !power_fault
		&& servo_off_stop_selector == 2'h1
		|=> state == ST_OFF_COAST && !power_enable && !short_circuit_brake)
		else $error("selector 1 did not end in coast");
	a_sel2_coast: assert property (
		state == ST_COAST_STOP |-> ##1 !short_circuit_brake && !power_enable
		|| $past(power_fault))
		else $error("coast stop drove brake or power");
	a_g2_zero: assert property (
		s_running_clean and (g2_zero && !sel_stop_req)
		|=> state == ST_ZERO_STOP ##1 speed_ref_out == 16'h0000)
		else $error("group two zero-speed stop missing");
	a_force_g2: assert property (
		s_running_clean and (g2_s && force_s) |=> state != ST_ZERO_STOP)
		else $error("zero-speed stop under force control");
	a_power_brake: assert property (
		state == ST_RUN && !ctrl_ok |=> state == ST_BRAKE_STOP
		##1 short_circuit_brake && !power_enable)
		else $error("control loss did not brake");
	a_ride_through: assert property (
		state == ST_RUN && outage_active && !outage_expired && ctrl_ok
		&& !uv_s && !sel_stop_req && !g2_zero |=> state == ST_RUN)
		else $error("servo dropped inside hold time");
	a_overspeed_latch: assert property (
		over_limit |=> overspeed [*2])
		else $error("overspeed not latched");
	a_zero_ref: assert property (
		state != ST_RUN |-> ##1 speed_ref_out == 16'h0000
		|| $past(next_state) == ST_RUN)
		else $error("speed reference not forced to zero");
endmodule // sas_stop_ctrl

// ===== core/sas_pkg.sv
// Constants for the stop-method and power-loss controller
package sas_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_HOLD = 8'h04;
	localparam logic [7:0] OFF_SPEED = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFF_COMMAND = 8'h18;
	// Config fields
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_G2_BIT = 4;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic G2_RESET = 1'b0;
	localparam logic [1:0] SEL_BRAKE_HOLD = 2'h0;
	localparam logic [1:0] SEL_COAST = 2'h2;
	// Hold time in ms, immediate effect
	localparam logic [9:0] HOLD_MIN = 10'h014;
	localparam logic [9:0] HOLD_MAX = 10'h3e8;
	localparam logic [9:0] HOLD_RESET = 10'h014;
	// Top speed in 100 mm/s units, loaded at restart
	localparam logic [6:0] SPEED_MIN = 7'h01;
	localparam logic [6:0] SPEED_MAX = 7'h64;
	localparam logic [6:0] SPEED_RESET = 7'h32;
	localparam logic [6:0] SPEED_UNIT_MMS = 7'h64;
	// Command bits
	localparam int CMD_RESTART_BIT = 0;
	localparam int CMD_CLEAR_BIT = 1;
	// Interrupt status bits
	localparam int IRQ_W = 7;
	localparam int IRQ_G1 = 0;
	localparam int IRQ_G2 = 1;
	localparam int IRQ_OVERSPEED = 2;
	localparam int IRQ_OUTAGE = 3;
	localparam int IRQ_EXPIRE = 4;
	localparam int IRQ_CTRL_LOSS = 5;
	localparam int IRQ_UNDERVOLT = 6;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 7'h00;
	// Millisecond time base
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_PERIOD_MS = 1;
	localparam int NS_PER_MS = 1000000;
	localparam int MS_CYCLES = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
	// Synchronised pin inputs; supplies reset as present
	localparam int PIN_W = 8;
	localparam logic [PIN_W-1:0] PIN_RESET = 8'h03;
	// Drive states
	typedef enum logic [2:0] {
		ST_OFF_COAST,
		ST_OFF_BRAKE,
		ST_RUN,
		ST_ZERO_STOP,
		ST_BRAKE_STOP,
		ST_COAST_STOP
	} sas_state_e;
endpackage

// ===== core/sas_sync.sv
// Two-stage synchroniser bank for pin inputs
module sas_sync
	import sas_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pins and synchronised copies
	input wire logic [PIN_W-1:0] pin_in,
	output logic [PIN_W-1:0] pin_sync
);
	logic [PIN_W-1:0] stage_one;

	genvar i;
	generate
		for (i = 0; i < PIN_W; i++)
		begin : g_bit
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					stage_one[i] <= PIN_RESET[i];
					pin_sync[i] <= PIN_RESET[i];
				end
				else
				begin
					stage_one[i] <= pin_in[i];
					pin_sync[i] <= stage_one[i];
				end
			end
		end
	endgenerate
endmodule // sas_sync

// ===== core/sas_outage_timer.sv
// Main-supply outage timer with millisecond prescaler
module sas_outage_timer
	import sas_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Supply state and hold setting
	input wire logic main_lost,
	input wire logic [9:0] hold_ms,
	// Timer state
	output logic outage_active,
	output logic outage_expired
);
	logic [31:0] prescale;
	logic [9:0] ms_count;
	wire tick = (prescale == 32'(TICK_CYCLES - 1));
	wire at_hold = (ms_count >= hold_ms);

	always_ff @(posedge clk)
	begin
		if (reset || !main_lost)
		begin
			prescale <= '0;
			ms_count <= '0;
			outage_active <= 1'b0;
			outage_expired <= 1'b0;
		end
		else
		begin
			outage_active <= 1'b1;
			prescale <= tick ? '0 : prescale + 32'h1;
			if (tick && ms_count != HOLD_MAX)
				ms_count <= ms_count + 10'h1;
			outage_expired <= at_hold;
		end
	end
endmodule // sas_outage_timer

// ===== bench/sas_host_model.sv
// Host motion controller model driving servo-on and speed reference
module sas_host_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Bench control
	input wire logic go,
	input wire logic [15:0] ref_level,
	// Drive-side pins
	output logic servo_on_request,
	output logic [15:0] speed_ref_in
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			servo_on_request <= 1'b0;
			speed_ref_in <= 16'h0000;
		end
		else
		begin
			servo_on_request <= go | (speed_ref_in != 16'h0000);
			speed_ref_in <= (go & servo_on_request) ? ref_level : 16'h0000;
		end
	end
endmodule // sas_host_model

// ===== bench/tb_top.sv
// Self-checking bench for the stop-method and power-loss controller
module tb_top
	import sas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 10;
	localparam logic [15:0] REF_LEVEL = 16'h0123;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic main_supply_ok = 1'b1;
	logic control_supply_ok = 1'b1;
	logic undervoltage_alarm = 1'b0;
	logic group_one_alarm = 1'b0;
	logic group_two_alarm = 1'b0;
	logic go = 1'b0;
	logic force_mode = 1'b0;
	logic motor_at_rest = 1'b1;
	logic servo_on_request;
	logic [15:0] speed_ref_in;
	logic [15:0] measured_speed = 16'h0;
	logic power_enable;
	logic short_circuit_brake;
	logic servo_running;
	logic [15:0] speed_ref_out;
	logic irq;
	int failures = 0;
	int n_checks = 0;

	always #20 clk = ~clk;

	sas_stop_ctrl #(.TICK_CYCLES(TICK)) i_sas_stop_ctrl (.clk(clk),
		.reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.main_supply_ok(main_supply_ok), .control_supply_ok(control_supply_ok),
		.undervoltage_alarm(undervoltage_alarm),
		.group_one_alarm(group_one_alarm), .group_two_alarm(group_two_alarm),
		.servo_on_request(servo_on_request), .force_mode(force_mode),
		.motor_at_rest(motor_at_rest), .speed_ref_in(speed_ref_in),
		.measured_speed(measured_speed), .power_enable(power_enable),
		.short_circuit_brake(short_circuit_brake),
		.servo_running(servo_running), .speed_ref_out(speed_ref_out),
		.irq(irq));

	sas_host_model i_sas_host_model (.clk(clk), .reset(reset), .go(go),
		.ref_level(REF_LEVEL), .servo_on_request(servo_on_request),
		.speed_ref_in(speed_ref_in));

	task report_and_stop;
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task timed_out;
		failures++;
		$display("MISMATCH t=%0t wait limit reached", $time);
		report_and_stop();
	endtask

	function automatic logic [15:0] obs(input int w);
		case (w)
			0: obs = {15'h0, servo_running};
			1: obs = {15'h0, short_circuit_brake};
			2: obs = {15'h0, power_enable};
			3: obs = {15'h0, irq};
			default: obs = speed_ref_out;
		endcase
	endfunction

	// Bounded wait for an output level, sampled mid-cycle
	task wait_out(input int w, input logic [15:0] v, input int lim,
		output int n);
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
			if (n > lim)
				timed_out();
		end
		while (obs(w) !== v);
		@(posedge clk);
	endtask

	task look(input int w, input logic [15:0] v);
		@(negedge clk);
		chk({16'h0, obs(w)}, {16'h0, v});
		@(posedge clk);
	endtask

	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (n > 50)
				timed_out();
		end
		while (hreadyout !== 1'b1);
	endtask

	task ahb_xfer(input logic wr_en, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr_en;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb_xfer(1'b1, a, d, q);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] q;
		ahb_xfer(1'b0, a, 32'h0, q);
		chk(q & m, exp);
	endtask

	task configure(input logic [31:0] cfg);
		wr(OFF_CONFIG, cfg);
		wr(OFF_COMMAND, 32'h1);
	endtask

	task start_run;
		int n;
		go <= 1'b0;
		motor_at_rest <= 1'b1;
		repeat (6) @(posedge clk);
		go <= 1'b1;
		motor_at_rest <= 1'b0;
		wait_out(0, 16'h1, 50, n);
		repeat (4) @(posedge clk);
	endtask

	task recover;
		group_one_alarm <= 1'b0;
		group_two_alarm <= 1'b0;
		undervoltage_alarm <= 1'b0;
		main_supply_ok <= 1'b1;
		control_supply_ok <= 1'b1;
		force_mode <= 1'b0;
		measured_speed <= 16'h0;
		go <= 1'b0;
		motor_at_rest <= 1'b1;
		repeat (6) @(posedge clk);
		wr(OFF_COMMAND, 32'h2);
	endtask

	task s_regs;
		rd_chk(OFF_CONFIG, 32'hffffffff, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		rd_chk(OFF_HOLD, 32'hffffffff, 32'h14);
		rd_chk(OFF_SPEED, 32'hffffffff, 32'h32);
		rd_chk(OFF_STATUS, 32'h7f00, 32'h3200);
		rd_chk(OFF_IRQ_MASK, 32'hffffffff, 32'h0);
		rd_chk(8'h1c, 32'hffffffff, 32'h0);
		wr(OFF_HOLD, 32'd19);
		rd_chk(OFF_HOLD, 32'hffffffff, 32'h14);
		wr(OFF_HOLD, 32'd1001);
		rd_chk(OFF_HOLD, 32'hffffffff, 32'h14);
		wr(OFF_HOLD, 32'd1044);
		rd_chk(OFF_HOLD, 32'hffffffff, 32'h14);
		wr(OFF_HOLD, 32'd1000);
		rd_chk(OFF_HOLD, 32'hffffffff, 32'h3e8);
		wr(OFF_SPEED, 32'h0);
		rd_chk(OFF_SPEED, 32'hffffffff, 32'h32);
		wr(OFF_SPEED, 32'h81);
		rd_chk(OFF_SPEED, 32'hffffffff, 32'h32);
		wr(OFF_CONFIG, 32'h3);
		rd_chk(OFF_CONFIG, 32'hffffffff, 32'h0);
	endtask

	task s_selector;
		int n;
		for (int s = 0; s < 3; s++)
		begin
			configure(s);
			start_run();
			group_one_alarm <= 1'b1;
			wait_out(2, 16'h0, 20, n);
			look(1, {15'h0, s != 2});
			motor_at_rest <= 1'b1;
			repeat (6) @(posedge clk);
			look(1, {15'h0, s == 0});
			rd_chk(OFF_STATUS, 32'h7, {31'h0, s == 0});
			recover();
		end
	endtask

	task s_group_two;
		int n;
		for (int k = 0; k < 4; k++)
		begin
			force_mode <= (k == 2);
			configure(k == 1 ? 32'h10 : k == 3 ? 32'h1 : 32'h0);
			start_run();
			group_two_alarm <= 1'b1;
			wait_out(0, 16'h0, 20, n);
			look(2, {15'h0, k == 0 || k == 3});
			look(4, 16'h0);
			look(1, {15'h0, k == 1 || k == 2});
			motor_at_rest <= 1'b1;
			repeat (6) @(posedge clk);
			look(1, {15'h0, k != 3});
			recover();
		end
	endtask

	task s_outage;
		int n;
		configure(32'h0);
		wr(OFF_HOLD, 32'd25);
		wr(OFF_IRQ_MASK, 32'h8);
		start_run();
		main_supply_ok <= 1'b0;
		wait_out(3, 16'h1, 20, n);
		rd_chk(OFF_IRQ_STAT, 32'h8, 32'h8);
		repeat (150) @(posedge clk);
		main_supply_ok <= 1'b1;
		repeat (400) @(posedge clk);
		look(0, 16'h1);
		look(4, REF_LEVEL);
		wr(OFF_IRQ_STAT, 32'h8);
		look(3, 16'h0);
		main_supply_ok <= 1'b0;
		wait_out(0, 16'h0, 400, n);
		chk({31'h0, n >= 240 && n <= 270}, 32'h1);
		look(1, 16'h1);
		recover();
	endtask

	task s_loss;
		int n;
		wr(OFF_IRQ_MASK, 32'h0);
		configure(32'h2);
		start_run();
		control_supply_ok <= 1'b0;
		wait_out(2, 16'h0, 20, n);
		look(1, 16'h1);
		look(3, 16'h0);
		rd_chk(OFF_IRQ_STAT, 32'h20, 32'h20);
		recover();
		start_run();
		main_supply_ok <= 1'b0;
		repeat (20) @(posedge clk);
		undervoltage_alarm <= 1'b1;
		wait_out(2, 16'h0, 20, n);
		look(1, 16'h1);
		recover();
	endtask

	task s_speed;
		int n;
		configure(32'h0);
		wr(OFF_SPEED, 32'h1);
		rd_chk(OFF_STATUS, 32'h7f00, 32'h3200);
		wr(OFF_COMMAND, 32'h1);
		rd_chk(OFF_STATUS, 32'h7f00, 32'h0100);
		start_run();
		measured_speed <= 16'd100;
		repeat (10) @(posedge clk);
		look(0, 16'h1);
		measured_speed <= 16'd101;
		wait_out(0, 16'h0, 20, n);
		look(1, 16'h1);
		rd_chk(OFF_STATUS, 32'h80, 32'h80);
		recover();
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		s_regs();
		s_selector();
		s_group_two();
		s_outage();
		s_loss();
		s_speed();
		report_and_stop();
	end
endmodule // tb_top
